// [src/akc_pkg.sv]
package akc_pkg;
   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam int AKC_ADDR_W = 16;
   localparam logic [15:0] AKC_OFF_CTRL = 16'h0000;
   localparam logic [15:0] AKC_OFF_GIE = 16'h0004;
   localparam logic [15:0] AKC_OFF_IER = 16'h0008;
   localparam logic [15:0] AKC_OFF_ISR = 16'h000C;
   localparam logic [15:0] AKC_OFF_ARG_LO = 16'h0010;
   localparam logic [15:0] AKC_OFF_ARG_HI = 16'h0014;
   localparam logic [15:0] AKC_OFF_MODE = 16'h0018;
   // ------------------------------------------------------------
   // Control word and single-bit register bit positions
   // ------------------------------------------------------------
   localparam int AKC_B_RUN = 0;
   localparam int AKC_B_DONE = 1;
   localparam int AKC_B_IDLE = 2;
   localparam int AKC_B_READY = 3;
   localparam int AKC_B_CONT = 4;
   localparam int AKC_B_AUTO = 7;
   localparam int AKC_B_EN = 0;
   // ------------------------------------------------------------
   // Responses, zero word and master burst settings
   // ------------------------------------------------------------
   localparam logic [1:0] AKC_RESP_OKAY = 2'h0;
   localparam logic [1:0] AKC_RESP_SLVERR = 2'h2;
   localparam logic [31:0] AKC_ZERO = 32'h0000_0000;
   localparam logic [1:0] AKC_BURST_INCR = 2'h1;
   localparam logic [2:0] AKC_SIZE_FULL = 3'h3;
   localparam logic [7:0] AKC_RUN_LEN = 8'h10;
   typedef enum logic {AKC_SEQ, AKC_PIPE} akc_mode_t;
endpackage : akc_pkg

// [src/akc_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// Two-stage pipeline register for the incoming reset
module akc_sync (
   input wire logic CLK_I,
   input wire logic D_I,
   output logic Q_O
);
   logic s1_q; // First stage, read only by second
   // ------------------------------------------------------------
   // Pipeline stages
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      s1_q <= D_I;
      Q_O <= s1_q;
   end
endmodule : akc_sync
`default_nettype wire

// [src/akc_kernel_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// Kernel control slave with run engine and base-offset master
module akc_kernel_ctrl
   import akc_pkg::*;
(
   input wire logic CLK_I, // Primary kernel clock
   input wire logic RESET_I, // Synchronous active high
   input wire logic PRIMARY_KERNEL_RESET_LOW_I, // Optional active low reset
   // AXI4-Lite control slave
   input wire logic [akc_pkg::AKC_ADDR_W-1:0] S_AXI_CONTROL_AWADDR_I,
   input wire logic S_AXI_CONTROL_AWVALID_I,
   output logic S_AXI_CONTROL_AWREADY_O,
   input wire logic [31:0] S_AXI_CONTROL_WDATA_I,
   input wire logic [3:0] S_AXI_CONTROL_WSTRB_I,
   input wire logic S_AXI_CONTROL_WVALID_I,
   output logic S_AXI_CONTROL_WREADY_O,
   output logic [1:0] S_AXI_CONTROL_BRESP_O,
   output logic S_AXI_CONTROL_BVALID_O,
   input wire logic S_AXI_CONTROL_BREADY_I,
   input wire logic [akc_pkg::AKC_ADDR_W-1:0] S_AXI_CONTROL_ARADDR_I,
   input wire logic S_AXI_CONTROL_ARVALID_I,
   output logic S_AXI_CONTROL_ARREADY_O,
   output logic [31:0] S_AXI_CONTROL_RDATA_O,
   output logic [1:0] S_AXI_CONTROL_RRESP_O,
   output logic S_AXI_CONTROL_RVALID_O,
   input wire logic S_AXI_CONTROL_RREADY_I,
   // AXI4 read master address and read data channels, global memory
   output logic [63:0] M_AXI_ARADDR_O,
   output logic [7:0] M_AXI_ARLEN_O,
   output logic [2:0] M_AXI_ARSIZE_O,
   output logic [1:0] M_AXI_ARBURST_O,
   output logic M_AXI_ARVALID_O,
   input wire logic M_AXI_ARREADY_I,
   input wire logic M_AXI_RLAST_I,
   input wire logic M_AXI_RVALID_I,
   output logic M_AXI_RREADY_O,
   // Active high interrupt
   output logic INTERRUPT_O
);
   import akc_pkg::*;

   // ------------------------------------------------------------
   // Reset pipeline
   // ------------------------------------------------------------
   logic rst_low_piped; // Pipelined optional reset
   logic rst; // Combined internal reset

   // Pipelined before use to ease timing
   akc_sync u_rst_pipe (
      .CLK_I(CLK_I),
      .D_I(PRIMARY_KERNEL_RESET_LOW_I),
      .Q_O(rst_low_piped)
   );
   // Either reset asserts the internal one; no second clock domain here
   assign rst = RESET_I | ~rst_low_piped;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic run_request_bit_q; // Host start request
   logic completion_flag_q; // Sticky done, read clears
   logic resume_permit_bit_q; // Host continue permission
   logic auto_restart_q; // Restart after each completion
   logic global_irq_enable_bit_q; // Global gate
   logic irq_source_enable_q; // Source gate
   logic irq_pending_q; // Pending interrupt status
   logic [63:0] arg_base_q; // Partition base offset
   akc_mode_t mode_q; // Sequential or pipelined
   logic busy_q; // Kernel processing
   logic hold_q; // Pipelined: held run resuming, permit present
   logic done_evt; // One-cycle completion event
   logic quiescent_flag; // Idle status
   logic accept_new_input_bit; // Ready status

   // ------------------------------------------------------------
   // Write channel: address and data taken together
   // ------------------------------------------------------------
   logic wr_go; // Write accepted this cycle
   logic [15:0] wr_addr; // Accepted write address
   logic [31:0] wdat; // Byte-masked write data

   // Accept only when both halves present and no response waits
   assign wr_go = S_AXI_CONTROL_AWVALID_I & S_AXI_CONTROL_WVALID_I & ~S_AXI_CONTROL_BVALID_O;
   assign S_AXI_CONTROL_AWREADY_O = wr_go;
   assign S_AXI_CONTROL_WREADY_O = wr_go;
   assign wr_addr = {S_AXI_CONTROL_AWADDR_I[15:2], 2'b00};
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wdat[i*8 +: 8] = S_AXI_CONTROL_WSTRB_I[i] ? S_AXI_CONTROL_WDATA_I[i*8 +: 8] : 8'h00;
      end
   end

   // Low-byte lane enable for the single-bit control fields
   logic wr_b0;
   assign wr_b0 = S_AXI_CONTROL_WSTRB_I[0];

   // Decode: known addresses answer OKAY, others SLVERR
   function automatic logic addr_known(input logic [15:0] a);
      addr_known = (a == AKC_OFF_CTRL) || (a == AKC_OFF_GIE) || (a == AKC_OFF_IER) ||
                   (a == AKC_OFF_ISR) || (a == AKC_OFF_ARG_LO) || (a == AKC_OFF_ARG_HI) ||
                   (a == AKC_OFF_MODE);
   endfunction : addr_known

   // Write response
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         S_AXI_CONTROL_BVALID_O <= 1'b0;
         S_AXI_CONTROL_BRESP_O <= AKC_RESP_OKAY;
      end else if (wr_go) begin
         S_AXI_CONTROL_BVALID_O <= 1'b1;
         S_AXI_CONTROL_BRESP_O <= addr_known(wr_addr) ? AKC_RESP_OKAY : AKC_RESP_SLVERR;
      end else if (S_AXI_CONTROL_BREADY_I) begin
         S_AXI_CONTROL_BVALID_O <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   logic rd_go; // Read accepted this cycle
   logic [15:0] rd_addr; // Accepted read address
   logic [31:0] rd_mux; // Selected read word

   assign rd_go = S_AXI_CONTROL_ARVALID_I & ~S_AXI_CONTROL_RVALID_O;
   assign S_AXI_CONTROL_ARREADY_O = rd_go;
   assign rd_addr = {S_AXI_CONTROL_ARADDR_I[15:2], 2'b00};

   // Read mux; reserved bits read zero
   always_comb begin
      rd_mux = AKC_ZERO;
      unique case (rd_addr)
         AKC_OFF_CTRL: begin
            rd_mux[AKC_B_RUN] = run_request_bit_q;
            rd_mux[AKC_B_DONE] = completion_flag_q;
            rd_mux[AKC_B_IDLE] = quiescent_flag;
            rd_mux[AKC_B_READY] = accept_new_input_bit;
            rd_mux[AKC_B_CONT] = resume_permit_bit_q;
            rd_mux[AKC_B_AUTO] = auto_restart_q;
         end
         AKC_OFF_GIE: rd_mux[AKC_B_EN] = global_irq_enable_bit_q;
         AKC_OFF_IER: rd_mux[AKC_B_EN] = irq_source_enable_q;
         AKC_OFF_ISR: rd_mux[AKC_B_EN] = irq_pending_q;
         AKC_OFF_ARG_LO: rd_mux = arg_base_q[31:0];
         AKC_OFF_ARG_HI: rd_mux = arg_base_q[63:32];
         AKC_OFF_MODE: rd_mux[AKC_B_EN] = (mode_q == AKC_PIPE);
         default: rd_mux = AKC_ZERO;
      endcase
   end

   // Read data register
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         S_AXI_CONTROL_RVALID_O <= 1'b0;
         S_AXI_CONTROL_RDATA_O <= AKC_ZERO;
         S_AXI_CONTROL_RRESP_O <= AKC_RESP_OKAY;
      end else if (rd_go) begin
         S_AXI_CONTROL_RVALID_O <= 1'b1;
         S_AXI_CONTROL_RDATA_O <= rd_mux;
         S_AXI_CONTROL_RRESP_O <= addr_known(rd_addr) ? AKC_RESP_OKAY : AKC_RESP_SLVERR;
      end else if (S_AXI_CONTROL_RREADY_I) begin
         S_AXI_CONTROL_RVALID_O <= 1'b0;
      end
   end

   logic ctrl_wr; // Write to control word
   logic ctrl_rd; // Read of control word
   assign ctrl_wr = wr_go && wr_b0 && (wr_addr == AKC_OFF_CTRL);
   assign ctrl_rd = rd_go && (rd_addr == AKC_OFF_CTRL);

   // ------------------------------------------------------------
   // Control word
   // ------------------------------------------------------------
   // Run request: host sets, completion clears unless auto restart is on
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         run_request_bit_q <= 1'b0;
      end else if (ctrl_wr && wdat[AKC_B_RUN]) begin
         run_request_bit_q <= 1'b1;
      end else if (done_evt && !auto_restart_q) begin
         run_request_bit_q <= 1'b0;
      end
   end

   // Completion flag: set wins over read clear
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         completion_flag_q <= 1'b0;
      end else if (done_evt) begin
         completion_flag_q <= 1'b1;
      end else if (ctrl_rd) begin
         completion_flag_q <= 1'b0;
      end
   end

   // Resume permit: host sets, consumed when a held run resumes
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         resume_permit_bit_q <= 1'b0;
      end else if (ctrl_wr && wdat[AKC_B_CONT]) begin
         resume_permit_bit_q <= 1'b1;
      end else if (hold_q) begin
         resume_permit_bit_q <= 1'b0;
      end
   end

   // Auto restart enable and other host-written settings
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         auto_restart_q <= 1'b0;
         global_irq_enable_bit_q <= 1'b0;
         irq_source_enable_q <= 1'b0;
         arg_base_q <= 64'h0;
         mode_q <= AKC_SEQ;
      end else if (wr_go) begin
         if (ctrl_wr) auto_restart_q <= wdat[AKC_B_AUTO];
         if (wr_b0 && wr_addr == AKC_OFF_GIE) global_irq_enable_bit_q <= wdat[AKC_B_EN];
         if (wr_b0 && wr_addr == AKC_OFF_IER) irq_source_enable_q <= wdat[AKC_B_EN];
         if (wr_addr == AKC_OFF_ARG_LO) begin
            // Keep the bytes whose strobe is low
            arg_base_q[31:0] <= (arg_base_q[31:0] & {{8{!S_AXI_CONTROL_WSTRB_I[3]}}, {8{!S_AXI_CONTROL_WSTRB_I[2]}},
               {8{!S_AXI_CONTROL_WSTRB_I[1]}}, {8{!wr_b0}}}) | wdat;
         end
         if (wr_addr == AKC_OFF_ARG_HI) begin
            arg_base_q[63:32] <= (arg_base_q[63:32] & ~{{8{S_AXI_CONTROL_WSTRB_I[3]}}, {8{S_AXI_CONTROL_WSTRB_I[2]}},
               {8{S_AXI_CONTROL_WSTRB_I[1]}}, {8{wr_b0}}}) | wdat;
         end
         if (wr_b0 && wr_addr == AKC_OFF_MODE) mode_q <= wdat[AKC_B_EN] ? AKC_PIPE : AKC_SEQ;
      end
   end

   // ------------------------------------------------------------
   // Run engine: fetches one burst from the partition base
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_HOLD} akc_state_t;
   akc_state_t st_q;

   // Sequential runs one at a time; pipelined waits for permit
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: if (run_request_bit_q) st_q <= ST_ADDR;
            ST_ADDR: if (M_AXI_ARREADY_I) st_q <= ST_DATA;
            ST_DATA: begin
               if (M_AXI_RVALID_I && M_AXI_RLAST_I) begin
                  st_q <= (mode_q == AKC_PIPE) ? ST_HOLD : ST_IDLE;
               end
            end
            ST_HOLD: if (resume_permit_bit_q) st_q <= ST_IDLE;
         endcase
      end
   end

   assign done_evt = (st_q == ST_DATA) && M_AXI_RVALID_I && M_AXI_RLAST_I;
   assign busy_q = (st_q != ST_IDLE);
   assign hold_q = (st_q == ST_HOLD) && resume_permit_bit_q;
   assign quiescent_flag = !busy_q && !run_request_bit_q;
   assign accept_new_input_bit = (st_q == ST_IDLE);

   // Master address channel, 64-bit, full-size incrementing
   assign M_AXI_ARADDR_O = arg_base_q;
   assign M_AXI_ARLEN_O = AKC_RUN_LEN - 8'h01;
   assign M_AXI_ARSIZE_O = AKC_SIZE_FULL;
   assign M_AXI_ARBURST_O = AKC_BURST_INCR;
   assign M_AXI_ARVALID_O = (st_q == ST_ADDR);
   // Read data only ever flows inward; no two-way stream
   assign M_AXI_RREADY_O = (st_q == ST_DATA);

   // ------------------------------------------------------------
   // Interrupt status and output
   // ------------------------------------------------------------
   // Completion with the source enabled raises status; a written one toggles it
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         irq_pending_q <= 1'b0;
      end else if (done_evt && irq_source_enable_q) begin
         irq_pending_q <= 1'b1;
      end else if (wr_go && wr_b0 && wr_addr == AKC_OFF_ISR && wdat[AKC_B_EN]) begin
         irq_pending_q <= ~irq_pending_q;
      end
   end

   // Registered AND of both enables and status
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         INTERRUPT_O <= 1'b0;
      end else begin
         INTERRUPT_O <= global_irq_enable_bit_q & irq_source_enable_q & irq_pending_q;
      end
   end
endmodule : akc_kernel_ctrl
`default_nettype wire

// [tb/akc_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// Port-level checker for the kernel control block
module akc_monitor
   import akc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic PRIMARY_KERNEL_RESET_LOW_I,
   input wire logic [15:0] S_AXI_CONTROL_AWADDR_I,
   input wire logic S_AXI_CONTROL_AWVALID_I,
   input wire logic S_AXI_CONTROL_AWREADY_O,
   input wire logic [31:0] S_AXI_CONTROL_WDATA_I,
   input wire logic S_AXI_CONTROL_WVALID_I,
   input wire logic S_AXI_CONTROL_WREADY_O,
   input wire logic [1:0] S_AXI_CONTROL_BRESP_O,
   input wire logic S_AXI_CONTROL_BVALID_O,
   input wire logic S_AXI_CONTROL_ARVALID_I,
   input wire logic S_AXI_CONTROL_ARREADY_O,
   input wire logic S_AXI_CONTROL_RVALID_O,
   input wire logic S_AXI_CONTROL_RREADY_I,
   input wire logic [63:0] M_AXI_ARADDR_O,
   input wire logic [7:0] M_AXI_ARLEN_O,
   input wire logic [2:0] M_AXI_ARSIZE_O,
   input wire logic [1:0] M_AXI_ARBURST_O,
   input wire logic M_AXI_ARVALID_O,
   input wire logic M_AXI_ARREADY_I,
   input wire logic M_AXI_RLAST_I,
   input wire logic M_AXI_RVALID_I,
   input wire logic M_AXI_RREADY_O,
   input wire logic INTERRUPT_O
);
   logic wt; // Write taken this cycle
   logic rt; // Read taken this cycle
   assign wt = S_AXI_CONTROL_AWVALID_I && S_AXI_CONTROL_WVALID_I && S_AXI_CONTROL_AWREADY_O && S_AXI_CONTROL_WREADY_O;
   assign rt = S_AXI_CONTROL_ARVALID_I && S_AXI_CONTROL_ARREADY_O;
   logic [2:0] lowrst_q; // Low reset history, spans the internal pipeline
   // Shadow of the two-stage reset pipeline plus one cycle
   always_ff @(posedge CLK_I) begin
      lowrst_q <= {lowrst_q[1:0], !PRIMARY_KERNEL_RESET_LOW_I};
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I || !PRIMARY_KERNEL_RESET_LOW_I || (lowrst_q != 3'h0));
   a_aw_answer: assert property (wt |=> S_AXI_CONTROL_BVALID_O) else $error("no write response");
   a_ar_answer: assert property (rt |=> S_AXI_CONTROL_RVALID_O) else $error("no read response");
   a_r_stands: assert property (S_AXI_CONTROL_RVALID_O && !S_AXI_CONTROL_RREADY_I |=> S_AXI_CONTROL_RVALID_O)
      else $error("read response dropped");
   a_unmapped_err: assert property (wt && S_AXI_CONTROL_AWADDR_I[15:2] > AKC_OFF_MODE[15:2] |=> S_AXI_CONTROL_BRESP_O == AKC_RESP_SLVERR)
      else $error("unmapped write not refused");
   a_burst_kind: assert property (M_AXI_ARVALID_O |-> M_AXI_ARBURST_O == AKC_BURST_INCR && M_AXI_ARSIZE_O == AKC_SIZE_FULL)
      else $error("bad burst kind");
   a_burst_len: assert property (M_AXI_ARVALID_O |-> M_AXI_ARLEN_O == 8'h0F) else $error("bad burst length");
   a_base_stable: assert property (M_AXI_ARVALID_O && !M_AXI_ARREADY_I |=> M_AXI_ARVALID_O && $stable(M_AXI_ARADDR_O))
      else $error("address request withdrawn");
   a_irq_gated: assert property (wt && S_AXI_CONTROL_AWADDR_I == AKC_OFF_GIE && !S_AXI_CONTROL_WDATA_I[0] |-> ##2 !INTERRUPT_O)
      else $error("interrupt not gated");
   // An enable or status write may also raise a pending interrupt
   a_irq_from_done: assert property ($rose(INTERRUPT_O) |-> $past(M_AXI_RVALID_I && M_AXI_RLAST_I && M_AXI_RREADY_O, 2) || $past(wt, 2))
      else $error("interrupt without completion");
   c_ctrl_write: cover property (wt && S_AXI_CONTROL_AWADDR_I == AKC_OFF_CTRL);
   c_last_beat: cover property (M_AXI_RVALID_I && M_AXI_RLAST_I);
   c_irq_rise: cover property ($rose(INTERRUPT_O));
endmodule : akc_monitor
bind akc_kernel_ctrl akc_monitor mon (.*);
`default_nettype wire

// [tb/akc_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Global memory responder for the read master
module akc_mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic arvalid_i,
   input wire logic [7:0] arlen_i,
   input wire logic rready_i,
   output logic arready_o,
   output logic rvalid_o,
   output logic rlast_o
);
   logic act_q; // Burst in progress
   logic gap_q; // Alternating stall phase
   logic [7:0] cnt_q; // Beats left minus one
   // Slow mode offers beats on alternate cycles only
   assign rvalid_o = act_q && (!slow_i || gap_q);
   // Last flag is noise outside valid beats, never a stale value
   assign rlast_o = rvalid_o ? (cnt_q == 8'h00) : gap_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arready_o <= 1'b0;
         act_q <= 1'b0;
         gap_q <= 1'b0;
         cnt_q <= 8'h00;
      end else begin
         // A beat once offered stands until taken
         gap_q <= (rvalid_o && !rready_i) ? gap_q : !gap_q;
         arready_o <= arvalid_i && !arready_o && !act_q && (!slow_i || gap_q);
         if (arvalid_i && arready_o) begin
            act_q <= 1'b1;
            cnt_q <= arlen_i;
         end else if (rvalid_o && rready_i) begin
            act_q <= (cnt_q != 8'h00);
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule : akc_mem_model
`default_nettype wire

// [tb/tb_akc_kernel_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_akc_kernel_ctrl;
   import akc_pkg::*;
   logic clk, rst, rst_n, awv, wv, arv, rr, slow, awr, wrdy, bv, arr, rv, marv, mrr, marr, mrv, mrl, irq;
   logic [15:0] awa, ara;
   logic [31:0] wd, rdat, cw;
   logic [3:0] ws; // Write byte strobes
   logic [1:0] bresp, rresp, mbur, resp;
   logic [63:0] maddr;
   logic [7:0] mlen;
   logic [2:0] msz;
   int err_total, compares, cyc;
   akc_kernel_ctrl dut (.CLK_I(clk), .RESET_I(rst), .PRIMARY_KERNEL_RESET_LOW_I(rst_n),
      .S_AXI_CONTROL_AWADDR_I(awa), .S_AXI_CONTROL_AWVALID_I(awv), .S_AXI_CONTROL_AWREADY_O(awr),
      .S_AXI_CONTROL_WDATA_I(wd), .S_AXI_CONTROL_WSTRB_I(ws), .S_AXI_CONTROL_WVALID_I(wv),
      .S_AXI_CONTROL_WREADY_O(wrdy), .S_AXI_CONTROL_BRESP_O(bresp), .S_AXI_CONTROL_BVALID_O(bv),
      .S_AXI_CONTROL_BREADY_I(1'b1), .S_AXI_CONTROL_ARADDR_I(ara), .S_AXI_CONTROL_ARVALID_I(arv),
      .S_AXI_CONTROL_ARREADY_O(arr), .S_AXI_CONTROL_RDATA_O(rdat), .S_AXI_CONTROL_RRESP_O(rresp),
      .S_AXI_CONTROL_RVALID_O(rv), .S_AXI_CONTROL_RREADY_I(rr), .M_AXI_ARADDR_O(maddr), .M_AXI_ARLEN_O(mlen),
      .M_AXI_ARSIZE_O(msz), .M_AXI_ARBURST_O(mbur), .M_AXI_ARVALID_O(marv), .M_AXI_ARREADY_I(marr),
      .M_AXI_RLAST_I(mrl), .M_AXI_RVALID_I(mrv), .M_AXI_RREADY_O(mrr), .INTERRUPT_O(irq));
   akc_mem_model mem (.clk_i(clk), .rst_i(rst), .slow_i(slow), .arvalid_i(marv), .arlen_i(mlen),
      .rready_i(mrr), .arready_o(marr), .rvalid_o(mrv), .rlast_o(mrl));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task chk(input logic [63:0] s, input logic [63:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
      end
   endtask : chk
   // Write: request held until both readies sampled
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do @(posedge clk); while (!(awr && wrdy));
      awv <= 1'b0;
      wv <= 1'b0;
      do @(posedge clk); while (!bv);
      resp = bresp;
   endtask : wr
   // Read: response is left standing one cycle before acceptance
   task rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      rr <= 1'b1;
      @(posedge clk);
      d = rdat;
      resp = rresp;
      rr <= 1'b0;
   endtask : rd
   task poll(input int b);
      rd(AKC_OFF_CTRL, cw);
      for (int i = 0; i < 200 && !cw[b]; i++) rd(AKC_OFF_CTRL, cw);
   endtask : poll
   task t_reset;
      rd(AKC_OFF_CTRL, cw);
      chk(cw, 32'h0000_000C);
      for (int a = 4; a < 16; a += 4) begin
         rd(a[15:0], cw);
         chk(cw, 32'h0);
      end
      $display("t_reset done");
   endtask : t_reset
   task t_regs;
      wr(AKC_OFF_GIE, 32'hFFFF_FFFF);
      rd(AKC_OFF_GIE, cw);
      chk(cw, 32'h1);
      wr(AKC_OFF_ARG_LO, 32'hFFFF_FFFF);
      wr(AKC_OFF_ARG_LO, 32'h9ABC_DEF0);
      wr(AKC_OFF_ARG_HI, 32'h1234_5678);
      ws <= 4'h3;
      wr(AKC_OFF_ARG_HI, 32'hFFFF_FFFF);
      ws <= 4'hF;
      rd(AKC_OFF_ARG_HI, cw);
      chk(cw, 32'h1234_FFFF);
      wr(16'h0020, 32'hFFFF_FFFF);
      chk(resp, AKC_RESP_SLVERR);
      rd(16'h0020, cw);
      chk(resp, AKC_RESP_SLVERR);
      rd(AKC_OFF_ARG_LO, cw);
      chk(cw, 32'h9ABC_DEF0);
      wr(AKC_OFF_IER, 32'h1);
      chk(resp, AKC_RESP_OKAY);
      $display("t_regs done");
   endtask : t_regs
   task t_seq;
      slow <= 1'b1;
      wr(AKC_OFF_CTRL, 32'h1);
      for (int i = 0; i < 50 && !marv; i++) @(posedge clk);
      chk(maddr, 64'h1234_FFFF_9ABC_DEF0);
      poll(AKC_B_DONE);
      chk(cw[2:0], 3'h6);
      chk(irq, 1'b1);
      rd(AKC_OFF_CTRL, cw);
      chk(cw[1], 1'b0);
      wr(AKC_OFF_ISR, 32'h1);
      @(posedge clk);
      chk(irq, 1'b0);
      $display("t_seq done");
   endtask : t_seq
   task t_auto;
      slow <= 1'b0;
      wr(AKC_OFF_CTRL, 32'h81);
      poll(AKC_B_DONE);
      chk({cw[7], cw[0]}, 2'h3);
      wr(AKC_OFF_CTRL, 32'h0);
      poll(AKC_B_IDLE);
      chk(cw[0], 1'b0);
      wr(AKC_OFF_ISR, 32'h1);
      $display("t_auto done");
   endtask : t_auto
   task t_pipe;
      wr(AKC_OFF_MODE, 32'h1);
      wr(AKC_OFF_CTRL, 32'h1);
      poll(AKC_B_DONE);
      chk(cw[3], 1'b0);
      wr(AKC_OFF_GIE, 32'h0);
      @(posedge clk);
      chk(irq, 1'b0);
      wr(AKC_OFF_CTRL, 32'h10);
      poll(AKC_B_READY);
      chk(cw[3], 1'b1);
      $display("t_pipe done");
   endtask : t_pipe
   // Idle pulse on the low reset alone, interrupt raised
   task t_lowrst;
      wr(AKC_OFF_GIE, 32'h1);
      @(posedge clk);
      chk(irq, 1'b1);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(irq, 1'b0);
      rd(AKC_OFF_GIE, cw);
      chk(cw, 32'h0);
      rd(AKC_OFF_CTRL, cw);
      chk(cw, 32'h0000_000C);
      $display("t_lowrst done");
   endtask : t_lowrst
   task wrap_up;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      {rst, rst_n, awv, wv, arv, rr, slow} = 7'h40;
      ws = 4'hF;
      {awa, ara, wd, err_total, compares, cyc} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_regs();
      t_seq();
      t_auto();
      t_pipe();
      t_lowrst();
      wrap_up();
   end
endmodule : tb_akc_kernel_ctrl
`default_nettype wire
